/* src/clsr_top.sv */
// setpoint register bank of the charge controller: input voltage limit,
// minimum system voltage and the reserved output current limit low byte
//
// Contract
// - input voltage code is 8 bits, split 6 high / 2 low; 64 mV LSB.
// - threshold adds a fixed 3.2 V to the weighted input voltage code.
// - input below threshold enters regulation and reduces charge current.
// - until programmed, threshold sits 1.28 V below no-load bus voltage.
// - reserved low-byte bits of the setpoints are ignored on write.
// - minimum system voltage is the high byte code, 100 mV LSB, no offset.
// - nonzero minimum system voltage writes below 1.0 V or above 23.0 V dropped.
// - reset clears minimum system voltage; start-up then loads it from the cell-count strap.
// - writing zero to minimum system voltage restores the strap default.
`timescale 1ns/1ns
module clsr_top
(
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire clsr_pkg::clsr_req_s        req,
   output logic [7:0]                      rdata,
   output logic                            rvalid,
   output logic                            invalid_write,
   output logic                            msv_write_dropped,
   input  wire logic [2:0]                 cell_count_strap,
   input  wire logic [15:0]                vbus_mv,
   input  wire logic [15:0]                vbus_noload_mv,
   output clsr_pkg::clsr_setpoint_s        setpoint,
   output logic                            input_voltage_regulation,
   output logic                            charge_current_reduce
);
   import clsr_pkg::*;

   // strap level after two flops
   logic [CLSR_STRAP_W-1:0] strap_sync;

   // byte pairing outputs
   logic        ivl_commit;
   logic [15:0] ivl_word;
   logic        msv_commit;
   logic [15:0] msv_word;

   // decoded write strobes
   logic ivl_lo_wr;
   logic ivl_hi_wr;
   logic ivl_hi_bad;
   logic msv_lo_wr;
   logic msv_hi_wr;

   // register state
   logic [7:0]     ivl_code_r, ivl_code_nxt;
   logic           ivl_prog_r, ivl_prog_nxt;
   logic [7:0]     msv_code_r, msv_code_nxt;
   logic [7:0]     msv_def_r, msv_def_nxt;
   clsr_state_e    state_r, state_nxt;
   logic           settle_r, settle_nxt;
   logic           dropped_r, dropped_nxt;
   logic           invalid_r, invalid_nxt;

   // read port state
   logic [7:0]     rdata_r, rdata_nxt;
   logic           rvalid_r, rvalid_nxt;

   // regulation outputs
   clsr_setpoint_s sp_r, sp_nxt;
   logic           ivreg_r, ivreg_nxt;
   logic [15:0]    ivl_mv;
   logic [15:0]    msv_mv;
   logic [15:0]    def_mv;
   logic [7:0]     strap_def;
   logic [7:0]     msv_new;

   // the strap pin is asynchronous to this clock
   clsr_sync #(.W(CLSR_STRAP_W)) u_strap_sync
   (
      .clock (clock),
      .rst   (rst),
      .pin   (cell_count_strap),
      .level (strap_sync)
   );

   // address decode of the byte bus
   always_comb
   begin
      ivl_lo_wr  = req.wr && (req.addr == CLSR_OFS_IVL_LOW);
      ivl_hi_bad = req.wr && (req.addr == CLSR_OFS_IVL_HIGH)
                   && (req.wdata[7:CLSR_IVL_RSV_POS] != 2'b00);
      // a high byte with reserved ones set is refused outright
      ivl_hi_wr  = req.wr && (req.addr == CLSR_OFS_IVL_HIGH)
                   && !ivl_hi_bad;
      msv_lo_wr  = req.wr && (req.addr == CLSR_OFS_MSV_LOW);
      msv_hi_wr  = req.wr && (req.addr == CLSR_OFS_MSV_HIGH);
   end

   // input voltage limit byte pair
   clsr_byte_pair u_ivl_pair
   (
      .clock  (clock),
      .rst    (rst),
      .lo_wr  (ivl_lo_wr),
      .hi_wr  (ivl_hi_wr),
      .wdata  (req.wdata),
      .commit (ivl_commit),
      .word   (ivl_word)
   );

   // minimum system voltage byte pair
   clsr_byte_pair u_msv_pair
   (
      .clock  (clock),
      .rst    (rst),
      .lo_wr  (msv_lo_wr),
      .hi_wr  (msv_hi_wr),
      .wdata  (req.wdata),
      .commit (msv_commit),
      .word   (msv_word)
   );

   // strap to default code; unknown straps fall back to one cell
   always_comb
   begin
      case (strap_sync)
         3'h2:    strap_def = CLSR_MSV_DEF_2S;
         3'h3:    strap_def = CLSR_MSV_DEF_3S;
         3'h4:    strap_def = CLSR_MSV_DEF_4S;
         3'h5:    strap_def = CLSR_MSV_DEF_5S;
         default: strap_def = CLSR_MSV_DEF_1S;
      endcase
   end

   // start-up sequence: let the synchroniser fill, then catch the strap
   always_comb
   begin
      state_nxt   = state_r;
      settle_nxt  = settle_r;
      msv_def_nxt = msv_def_r;
      case (state_r)
         CLSR_ST_SETTLE:
         begin
            settle_nxt = 1'b1;
            if (settle_r)
               state_nxt = CLSR_ST_LOAD;
         end
         CLSR_ST_LOAD:
         begin
            msv_def_nxt = strap_def;
            state_nxt   = CLSR_ST_RUN;
         end
         CLSR_ST_RUN:
            state_nxt = CLSR_ST_RUN;
         default:
            state_nxt = CLSR_ST_SETTLE;
      endcase
   end

   // input voltage code: reserved low six bits never stored
   always_comb
   begin
      ivl_code_nxt = ivl_code_r;
      ivl_prog_nxt = ivl_prog_r;
      invalid_nxt  = ivl_hi_bad;
      if (ivl_commit)
      begin
         ivl_code_nxt = {ivl_word[8 +: CLSR_IVL_HI_W],
                         ivl_word[CLSR_IVL_LO_POS +: 2]};
         ivl_prog_nxt = 1'b1;
      end
   end

   // minimum system voltage: low byte is discarded whole
   always_comb
   begin
      msv_new      = msv_word[15:8];
      msv_code_nxt = msv_code_r;
      dropped_nxt  = 1'b0;
      if (state_r == CLSR_ST_LOAD)
         msv_code_nxt = strap_def;
      else if (msv_commit)
      begin
         if (msv_new == 8'h00)
            msv_code_nxt = msv_def_r;
         else if ((msv_new < CLSR_MSV_CODE_MIN)
                  || (msv_new > CLSR_MSV_CODE_MAX))
            dropped_nxt = 1'b1;
         else
            msv_code_nxt = msv_new;
      end
   end

   // setpoints in mV; widths fit since 3200 + 255*64 and 255*100 < 2^16
   always_comb
   begin
      ivl_mv = CLSR_IVL_OFFSET_MV
               + 16'(ivl_code_r * CLSR_IVL_LSB_MV);
      msv_mv = 16'(msv_code_r * CLSR_MSV_LSB_MV);
      // clamp so a dead bus does not wrap to a huge threshold
      if (vbus_noload_mv > CLSR_IVL_DEFAULT_MV)
         def_mv = vbus_noload_mv - CLSR_IVL_DEFAULT_MV;
      else
         def_mv = 16'h0000;
   end

   // regulation flag follows the live bus each cycle
   always_comb
   begin
      sp_nxt.ivl_threshold_mv = ivl_prog_r ? ivl_mv : def_mv;
      sp_nxt.min_system_mv    = msv_mv;
      ivreg_nxt = (vbus_mv < sp_r.ivl_threshold_mv);
   end

   // read port: committed values only, staged bytes stay hidden
   always_comb
   begin
      rvalid_nxt = req.rd;
      rdata_nxt  = rdata_r;
      if (req.rd)
      begin
         case (req.addr)
            CLSR_OFS_IVL_LOW:
               rdata_nxt = {ivl_code_r[1:0], 6'h00};
            CLSR_OFS_IVL_HIGH:
               rdata_nxt = {2'b00, ivl_code_r[7:2]};
            CLSR_OFS_MSV_HIGH:
               rdata_nxt = msv_code_r;
            default:
               rdata_nxt = CLSR_RSV_READ;
         endcase
      end
   end

   // start-up sequencer flops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r   <= CLSR_ST_SETTLE;
         settle_r  <= 1'b0;
         msv_def_r <= CLSR_MSV_CODE_RST;
      end
      else
      begin
         state_r   <= state_nxt;
         settle_r  <= settle_nxt;
         msv_def_r <= msv_def_nxt;
      end
   end

   // input voltage code flops; the refusal flag is a pulse, never held
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ivl_code_r <= CLSR_IVL_CODE_RST;
         ivl_prog_r <= 1'b0;
         invalid_r  <= 1'b0;
      end
      else
      begin
         ivl_code_r <= ivl_code_nxt;
         ivl_prog_r <= ivl_prog_nxt;
         invalid_r  <= invalid_nxt;
      end
   end

   // minimum system voltage flops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         msv_code_r <= CLSR_MSV_CODE_RST;
         dropped_r  <= 1'b0;
      end
      else
      begin
         msv_code_r <= msv_code_nxt;
         dropped_r  <= dropped_nxt;
      end
   end

   // read port flops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // setpoint and regulation flops
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sp_r    <= '0;
         ivreg_r <= 1'b0;
      end
      else
      begin
         sp_r    <= sp_nxt;
         ivreg_r <= ivreg_nxt;
      end
   end

   // outputs straight from flops
   assign rdata                    = rdata_r;
   assign rvalid                   = rvalid_r;
   assign invalid_write            = invalid_r;
   assign msv_write_dropped        = dropped_r;
   assign setpoint                 = sp_r;
   assign input_voltage_regulation = ivreg_r;
   assign charge_current_reduce    = ivreg_r;
endmodule

/* src/clsr_pkg.sv */
// package: offsets, fields, defaults and carriers of the setpoint bank
package clsr_pkg;

   // byte addresses of the setpoint bank
   localparam logic [7:0] CLSR_OFS_OCL_LOW  = 8'h08;
   localparam logic [7:0] CLSR_OFS_IVL_LOW  = 8'h0A;
   localparam logic [7:0] CLSR_OFS_IVL_HIGH = 8'h0B;
   localparam logic [7:0] CLSR_OFS_MSV_LOW  = 8'h0C;
   localparam logic [7:0] CLSR_OFS_MSV_HIGH = 8'h0D;

   // input voltage limit field layout
   localparam int CLSR_IVL_LO_POS   = 6;  // low byte bits 7..6 = code 1..0
   localparam int CLSR_IVL_HI_W     = 6;  // high byte bits 5..0 = code 7..2
   localparam int CLSR_IVL_RSV_POS  = 6;  // high byte bits 7..6 reserved
   localparam logic [7:0] CLSR_IVL_CODE_RST = 8'h00;

   // weights and offsets in mV
   localparam logic [15:0] CLSR_IVL_LSB_MV     = 16'h0040; // 64 mV
   localparam logic [15:0] CLSR_IVL_MSB_MV     = 16'h2000; // 8192 mV
   localparam logic [15:0] CLSR_IVL_OFFSET_MV  = 16'h0C80; // 3.2 V
   localparam logic [15:0] CLSR_IVL_DEFAULT_MV = 16'h0500; // 1.28 V
   localparam logic [15:0] CLSR_MSV_LSB_MV     = 16'h0064; // 100 mV
   localparam logic [15:0] CLSR_MSV_MSB_MV     = 16'h3200; // 12800 mV

   // accepted minimum system voltage codes: 1.0 V .. 23.0 V
   localparam logic [7:0] CLSR_MSV_CODE_MIN = 8'h0A;
   localparam logic [7:0] CLSR_MSV_CODE_MAX = 8'hE6;
   localparam logic [7:0] CLSR_MSV_CODE_RST = 8'h00;

   // cell-count strap defaults (codes of 100 mV)
   localparam logic [7:0] CLSR_MSV_DEF_1S = 8'h24; // 3.6 V
   localparam logic [7:0] CLSR_MSV_DEF_2S = 8'h42; // 6.6 V
   localparam logic [7:0] CLSR_MSV_DEF_3S = 8'h5C; // 9.2 V
   localparam logic [7:0] CLSR_MSV_DEF_4S = 8'h7B; // 12.3 V
   localparam logic [7:0] CLSR_MSV_DEF_5S = 8'h9A; // 15.4 V
   localparam int CLSR_STRAP_W = 3;

   // reserved bytes read back as zero
   localparam logic [7:0] CLSR_RSV_READ = 8'h00;

   // one byte access from the serial host controller
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } clsr_req_s;

   // setpoints handed to the regulation loops
   typedef struct packed
   {
      logic [15:0] ivl_threshold_mv;
      logic [15:0] min_system_mv;
   } clsr_setpoint_s;

   typedef enum logic [1:0] {CLSR_ST_SETTLE, CLSR_ST_LOAD, CLSR_ST_RUN}
      clsr_state_e;

endpackage

/* src/clsr_sync.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/1ns
module clsr_sync #(parameter int W = 1)
(
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] level_r;
   logic [W-1:0] level_nxt;

   // first stage feeds only the second
   always_comb
   begin
      meta_nxt  = pin;
      level_nxt = meta_r;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_r  <= '0;
         level_r <= '0;
      end
      else
      begin
         meta_r  <= meta_nxt;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule

/* src/clsr_byte_pair.sv */
// joins two byte writes into one 16-bit setpoint update
`timescale 1ns/1ns
module clsr_byte_pair
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        lo_wr,
   input  wire logic        hi_wr,
   input  wire logic [7:0]  wdata,
   output logic             commit,
   output logic [15:0]      word
);
   logic [7:0] lo_r, lo_nxt;
   logic [7:0] hi_r, hi_nxt;
   logic       lo_seen_r, lo_seen_nxt;
   logic       hi_seen_r, hi_seen_nxt;
   logic       commit_r, commit_nxt;

   // either order; a byte written twice keeps its latest value
   always_comb
   begin
      lo_nxt      = lo_wr ? wdata : lo_r;
      hi_nxt      = hi_wr ? wdata : hi_r;
      lo_seen_nxt = lo_seen_r | lo_wr;
      hi_seen_nxt = hi_seen_r | hi_wr;
      commit_nxt  = 1'b0;
      if (lo_seen_nxt && hi_seen_nxt)
      begin
         commit_nxt  = 1'b1;
         lo_seen_nxt = 1'b0;
         hi_seen_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lo_r      <= 8'h00;
         hi_r      <= 8'h00;
         lo_seen_r <= 1'b0;
         hi_seen_r <= 1'b0;
         commit_r  <= 1'b0;
      end
      else
      begin
         lo_r      <= lo_nxt;
         hi_r      <= hi_nxt;
         lo_seen_r <= lo_seen_nxt;
         hi_seen_r <= hi_seen_nxt;
         commit_r  <= commit_nxt;
      end
   end

   assign commit = commit_r;
   assign word   = {hi_r, lo_r};
endmodule

/* testbench/clsr_top_chk.sv */
// assertion checker watching the setpoint bank ports
`timescale 1ns/1ns
module clsr_top_chk
(
   input wire logic                     clock,
   input wire logic                     rst,
   input wire clsr_pkg::clsr_req_s      req,
   input wire logic [7:0]               rdata,
   input wire logic                     rvalid,
   input wire logic                     invalid_write,
   input wire logic                     msv_write_dropped,
   input wire logic [2:0]               cell_count_strap,
   input wire logic [15:0]              vbus_mv,
   input wire logic [15:0]              vbus_noload_mv,
   input wire clsr_pkg::clsr_setpoint_s setpoint,
   input wire logic                     input_voltage_regulation,
   input wire logic                     charge_current_reduce
);
   import clsr_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic       lo_wr_r;
   logic [1:0] lo_bits_r;
   logic       ivl_go;
   logic [7:0] ivl_code;
   logic       bad_hi;
   // low byte of the previous cycle, so a back-to-back pair is visible
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lo_wr_r   <= 1'b0;
         lo_bits_r <= 2'h0;
      end
      else
      begin
         lo_wr_r   <= req.wr && req.addr == 8'h0A;
         lo_bits_r <= req.wdata[7:6];
      end
   end
   // pairs only: a lone high byte waits and commits later with the next low byte
   assign bad_hi = req.wr && req.addr == 8'h0B && req.wdata[7:6] != 2'h0;
   assign ivl_go = req.wr && req.addr == 8'h0B && !bad_hi && lo_wr_r;
   assign ivl_code = {req.wdata[5:0], lo_bits_r};

   AST_RVALID: assert property (rvalid == $past(req.rd))
      else $error("read answer not one cycle after request");
   AST_INV_PULSE: assert property (bad_hi |=> invalid_write ##1
      $stable(setpoint.ivl_threshold_mv)[*3])
      else $error("refused high byte not flagged or applied");
   AST_INV_CAUSE: assert property (invalid_write |-> $past(bad_hi))
      else $error("invalid write flag without cause");
   AST_CCR_TIED: assert property
      (charge_current_reduce == input_voltage_regulation)
      else $error("current reduce differs from regulation");
   AST_REGULATE: assert property (input_voltage_regulation ==
      $past(vbus_mv < setpoint.ivl_threshold_mv))
      else $error("regulation does not follow input voltage");
   AST_IVL_CODE: assert property ($past(ivl_go, 3) |->
      setpoint.ivl_threshold_mv == 16'h0C80 + {$past(ivl_code, 3), 6'h00})
      else $error("input voltage threshold wrong after pair");
   AST_RSV_BYTES: assert property (rvalid &&
      ($past(req.addr) == 8'h08 || $past(req.addr) == 8'h0C) |-> rdata == 0)
      else $error("reserved byte read not zero");
   AST_IVL_LOW: assert property (rvalid && $past(req.addr) == 8'h0A
      |-> rdata[5:0] == 6'h00)
      else $error("input voltage low byte reserved bits not zero");
   AST_MSV_RANGE: assert property (setpoint.min_system_mv != 0 |->
      setpoint.min_system_mv inside {[16'd1000:16'd23000]} &&
      setpoint.min_system_mv % 16'd100 == 0)
      else $error("minimum system voltage out of range");
   AST_MSV_DROP: assert property (msv_write_dropped |=>
      $stable(setpoint.min_system_mv)[*3])
      else $error("dropped minimum system write was applied");
endmodule

/* testbench/clsr_host.sv */
// host model issuing single-cycle byte accesses to the setpoint bank
`timescale 1ns/1ns
module clsr_host
(
   input  wire logic          clock,
   input  wire logic [7:0]    rdata,
   output clsr_pkg::clsr_req_s req
);
   import clsr_pkg::*;
   initial req = '0;
   // low byte then high byte on consecutive edges
   task automatic wr2(input logic [7:0] a, lo, hi);
      req <= '{1'b1, 1'b0, a, lo};
      @(posedge clock);
      req <= '{1'b1, 1'b0, a + 8'h01, hi};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask
   // lone byte, used for refusals, the reverse pair and reserved places
   task automatic wr1(input logic [7:0] a, d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask
   // read data is taken a step after the edge that follows the answering edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
      #1 d = rdata;
      @(posedge clock);
   endtask
endmodule

/* testbench/clsr_top_bench.sv */
// self-checking bench of the setpoint register bank
`timescale 1ns/1ns
module clsr_top_bench;
   import clsr_pkg::*;
   logic           clock = 1'b0;
   logic           rst = 1'b1;
   clsr_req_s      req;
   logic [7:0]     rdata, d, c, pv;
   logic           rvalid, invalid_write, msv_write_dropped;
   logic [2:0]     cell_count_strap = 3'h0;
   logic [15:0]    vbus_mv = 16'h0000;
   logic [15:0]    vbus_noload_mv = 16'h0000;
   clsr_setpoint_s setpoint;
   logic           ivr, ccr;
   int             error_cnt = 0;
   int             check_count = 0;
   logic [7:0]     msv_tab [6] = '{8'h09, 8'h0A, 8'hE6, 8'hE7, 8'hFF, 8'h00};

   always #10 clock = ~clock;

   clsr_host host (.clock(clock), .rdata(rdata), .req(req));
   clsr_top DUT (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
      .rvalid(rvalid), .invalid_write(invalid_write),
      .msv_write_dropped(msv_write_dropped),
      .cell_count_strap(cell_count_strap), .vbus_mv(vbus_mv),
      .vbus_noload_mv(vbus_noload_mv), .setpoint(setpoint),
      .input_voltage_regulation(ivr), .charge_current_reduce(ccr));

   function automatic logic [15:0] ivl_exp(input logic [7:0] k);
      return 16'h0C80 + {2'h0, k, 6'h00};
   endfunction
   function automatic logic [7:0] msv_def(input logic [2:0] s);
      case (s)
         3'h2: return 8'h42;
         3'h3: return 8'h5C;
         3'h4: return 8'h7B;
         3'h5: return 8'h9A;
         default: return 8'h24;
      endcase
   endfunction
   function automatic logic [15:0] mv(input logic [7:0] k);
      return {8'h00, k} * 16'h0064;
   endfunction

   task automatic check(input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // strap must settle before release, start-up load takes four edges
   task automatic do_reset(input logic [2:0] s);
      rst <= 1'b1;
      cell_count_strap <= s;
      vbus_noload_mv <= 16'(4000 + $urandom_range(16000));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      conclude();
   end

   initial
   begin
      void'($urandom(32'h1665AD4B));
      @(posedge clock);
      for (int s = 0; s < 8; s++)
      begin
         do_reset(3'(s));
         check(setpoint.ivl_threshold_mv, vbus_noload_mv - 16'h0500);
         check(setpoint.min_system_mv, mv(msv_def(3'(s))));
         host.wr2(8'h0C, 8'($urandom), 8'h42);
         repeat (3) @(posedge clock);
         check(setpoint.min_system_mv, mv(8'h42));
         host.wr2(8'h0C, 8'h00, 8'h00);
         repeat (3) @(posedge clock);
         check(setpoint.min_system_mv, mv(msv_def(3'(s))));
      end
      // input voltage codes, corners first, reserved low bits random
      for (int i = 0; i < 14; i++)
      begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         host.wr2(8'h0A, {c[1:0], 6'($urandom)}, {2'h0, c[7:2]});
         repeat (3) @(posedge clock);
         check(setpoint.ivl_threshold_mv, ivl_exp(c));
         host.rd(8'h0B, d);
         check({8'h00, d}, {10'h000, c[7:2]});
         host.rd(8'h0A, d);
         check({8'h00, d}, {8'h00, c[1:0], 6'h00});
         vbus_mv <= ivl_exp(c) - 16'h0001;
         repeat (3) @(posedge clock);
         check({15'h0000, ivr}, 16'h0001);
         vbus_mv <= ivl_exp(c);
         repeat (3) @(posedge clock);
         check({15'h0000, ivr}, 16'h0000);
      end
      // refused high bytes leave the threshold alone
      for (int i = 1; i < 4; i++)
      begin
         host.wr1(8'h0B, {2'(i), 6'($urandom)});
         repeat (3) @(posedge clock);
         check(setpoint.ivl_threshold_mv, ivl_exp(c));
      end
      // reverse pair: a lone high byte waits, the low byte completes it
      host.wr1(8'h0B, 8'h15);
      repeat (3) @(posedge clock);
      check(setpoint.ivl_threshold_mv, ivl_exp(c));
      host.wr1(8'h0A, 8'h80);
      repeat (3) @(posedge clock);
      check(setpoint.ivl_threshold_mv, ivl_exp(8'h56));
      // minimum system codes: boundaries, zero, then random
      pv = msv_def(3'h7);
      for (int i = 0; i < 16; i++)
      begin
         c = (i < 6) ? msv_tab[i] : 8'($urandom);
         host.wr2(8'h0C, 8'($urandom), c);
         repeat (3) @(posedge clock);
         if (c == 8'h00)
            pv = msv_def(3'h7);
         else if (c >= 8'h0A && c <= 8'hE6)
            pv = c;
         check(setpoint.min_system_mv, mv(pv));
         host.rd(8'h0D, d);
         check({8'h00, d}, {8'h00, pv});
         host.rd(8'h0C, d);
         check({8'h00, d}, 16'h0000);
      end
      // reserved output current byte and an unmapped place read zero
      host.wr1(8'h08, 8'($urandom));
      host.rd(8'h08, d);
      check({8'h00, d}, 16'h0000);
      host.rd(8'h20, d);
      check({8'h00, d}, 16'h0000);
      conclude();
   end
endmodule

bind clsr_top clsr_top_chk u_chk (.clock(clock), .rst(rst), .req(req),
   .rdata(rdata), .rvalid(rvalid), .invalid_write(invalid_write),
   .msv_write_dropped(msv_write_dropped),
   .cell_count_strap(cell_count_strap), .vbus_mv(vbus_mv),
   .vbus_noload_mv(vbus_noload_mv), .setpoint(setpoint),
   .input_voltage_regulation(input_voltage_regulation),
   .charge_current_reduce(charge_current_reduce));
